// file: hw/sequencer_pkg.sv
/*
  shared constants, state types and a line-address helper for the
  write-back bus sequencer and its buffer; assumes 32-bit words and a
  16-byte line of four words
*/
package sequencer_pkg;
  localparam int WORD_W = 32;
  localparam int LINE_W = 28;
  localparam int LINE_LSB = 4;
  localparam int OFFSET_LSB = 2;
  localparam int LINE_WORDS = 4;
  localparam int FIFO_WORDS = 8;
  localparam logic [1:0] FIRST_BEAT = 2'h0;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [2:0] LOAD_FULL = 3'h4;
  localparam logic [3:0] LINE_OFFSET0 = 4'h0;
  localparam logic SNOOP_MODIFIED_HIT_IDLE = 1'b1;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_type;

  typedef enum logic [1:0] {
    KIND_READ = 2'b00,
    KIND_WRITE = 2'b01,
    KIND_WB = 2'b10
  } cycle_kind_type;

  // line number of a byte address, used by snoop compare and write-back
  function automatic logic [LINE_W-1:0] line_of(input logic [WORD_W-1:0] a);
    line_of = a[WORD_W-1:LINE_LSB];
  endfunction : line_of
endpackage : sequencer_pkg

// file: hw/snoop_writeback_bus_sequencer.sv
/*
  bus sequencer of a write-back cache: line fills, single writes,
  yield handshake, snoop pipeline and snoop-hit write-back;
  assumes all inputs synchronous to mclk and a cache that answers a
  snoop probe with probeModified in the following clock
*/
`timescale 1ns/100ps
module snoop_writeback_bus_sequencer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cpuReqValid,
  input wire logic cpuReqWrite,
  input wire logic [31:0] cpuReqAddr,
  input wire logic [31:0] cpuReqData,
  output logic cpuReqReady,
  output logic [31:0] cpuReadData,
  output logic cpuReadValid,
  output logic fillWriteBack,
  output logic snoopProbe,
  output logic [27:0] snoopProbeLine,
  input wire logic probeModified,
  input wire logic copyBackValid,
  input wire logic [27:0] copyBackLine,
  input wire logic lineWordValid,
  input wire logic [31:0] lineWord,
  output logic lineWordReady,
  output logic lineStateUpdate,
  output logic lineInvalidate,
  output logic cycleStartStrobeN,
  output logic writeNotRead,
  output logic burstLineCycleN,
  output logic finalTransferFlagN,
  input wire logic burstReadyN,
  input wire logic lineWritebackSelect,
  output logic [31:0] addrOut,
  output logic addrOe,
  input wire logic [31:0] addrIn,
  output logic [31:0] dataOut,
  output logic dataOe,
  input wire logic [31:0] dataIn,
  input wire logic busYieldReq,
  output logic busYieldAck,
  input wire logic snoopAddrStrobeN,
  input wire logic snoopDiscardLine,
  output logic snoopModifiedHitN
);
  sequencer_pkg::bus_state_type state_q, state_d;
  sequencer_pkg::cycle_kind_type kind_q, kind_d;
  logic [1:0] beat_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic fillWb_q;
  logic ack_q;
  logic probeStage_q;
  logic [27:0] snoopLine_q;
  logic discard_q;
  logic hitmN_q;
  logic wbPend_q;
  logic [27:0] wbLine_q;
  logic [2:0] loadCnt_q;
  logic update_q;
  logic invalidate_q;

  word_stream_if #(.W(sequencer_pkg::WORD_W)) fifoIn();
  word_stream_if #(.W(sequencer_pkg::WORD_W)) fifoOut();

  // modified line words wait here until the write-back burst drains them
  word_fifo #(
    .WIDTH(sequencer_pkg::WORD_W),
    .DEPTH(sequencer_pkg::FIFO_WORDS)
  ) lineBuffer (
    .mclk(mclk),
    .reset(reset),
    .inPort(fifoIn.sink),
    .outPort(fifoOut.source)
  );

  // decode of the bus state
  wire stIdle = (state_q == sequencer_pkg::BUS_IDLE);
  wire stAddr = (state_q == sequencer_pkg::BUS_ADDR);
  wire stData = (state_q == sequencer_pkg::BUS_DATA);
  wire isWb = (kind_q == sequencer_pkg::KIND_WB);
  wire isRead = (kind_q == sequencer_pkg::KIND_READ);
  wire beatDone = stData && !burstReadyN;
  wire lastBeat = (kind_q == sequencer_pkg::KIND_WRITE)
                  || (beat_q == sequencer_pkg::LAST_BEAT);
  wire cycleDone = beatDone && lastBeat;
  wire wbDone = cycleDone && isWb;
  wire lineLoaded = (loadCnt_q == sequencer_pkg::LOAD_FULL);

  // the write-back waits for the whole line and a released request
  wire wbGo = stIdle && wbPend_q && lineLoaded && !busYieldReq;
  // processor accesses yield to the request and to any pending write-back
  wire cpuGo = stIdle && cpuReqValid && !busYieldReq && !wbPend_q;

  // snoop pipeline: strobe taken only while yielded and no write-back owed
  wire snoopAccept = ack_q && !snoopAddrStrobeN && !wbPend_q
                     && hitmN_q && !probeStage_q;
  wire cbMatch = copyBackValid && (copyBackLine == snoopLine_q);
  wire modHit = probeStage_q && (probeModified || cbMatch);

  // ack only from an idle bus; holds through a modified hit until release
  wire ackNext = busYieldReq && stIdle && (ack_q || !wbPend_q);

  assign cpuReqReady = cpuGo && !wbGo;
  assign snoopProbe = snoopAccept;
  assign snoopProbeLine = sequencer_pkg::line_of(addrIn);
  assign fifoIn.valid = lineWordValid && wbPend_q && !lineLoaded;
  assign fifoIn.data = lineWord;
  assign lineWordReady = fifoIn.ready && wbPend_q && !lineLoaded;
  assign fifoOut.ready = beatDone && isWb;

  // bus pins decoded from state; strobe only in the address cycle
  assign cycleStartStrobeN = !stAddr;
  assign writeNotRead = !isRead && !stIdle;
  assign burstLineCycleN = !(stAddr && !(kind_q == sequencer_pkg::KIND_WRITE));
  assign finalTransferFlagN = !(stData && lastBeat);
  assign addrOut = addr_q;
  assign addrOe = !stIdle;
  assign dataOut = isWb ? fifoOut.data : wdata_q;
  assign dataOe = stData && !isRead;
  assign busYieldAck = ack_q;
  assign snoopModifiedHitN = hitmN_q;
  assign cpuReadData = rdata_q;
  assign cpuReadValid = rvalid_q;
  assign fillWriteBack = fillWb_q;
  assign lineStateUpdate = update_q;
  assign lineInvalidate = invalidate_q;

  // next bus state; write-back has priority over processor work
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    case (state_q)
      sequencer_pkg::BUS_IDLE:
      begin
        if (wbGo)
        begin
          state_d = sequencer_pkg::BUS_ADDR;
          kind_d = sequencer_pkg::KIND_WB;
        end
        else if (cpuGo)
        begin
          state_d = sequencer_pkg::BUS_ADDR;
          kind_d = cpuReqWrite ? sequencer_pkg::KIND_WRITE : sequencer_pkg::KIND_READ;
        end
      end
      sequencer_pkg::BUS_ADDR: state_d = sequencer_pkg::BUS_DATA;
      sequencer_pkg::BUS_DATA:
      begin
        if (cycleDone)
          state_d = sequencer_pkg::BUS_IDLE;
      end
      default: state_d = sequencer_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= sequencer_pkg::BUS_IDLE;
      kind_q <= sequencer_pkg::KIND_READ;
      ack_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      ack_q <= ackNext;
    end
  end

  // address and beat counter; write-back always from offset 0
  always_ff @(posedge mclk)
  begin
    if (reset)
      beat_q <= sequencer_pkg::FIRST_BEAT;
    else if (stAddr)
      beat_q <= sequencer_pkg::FIRST_BEAT;
    else if (beatDone)
      beat_q <= 2'(beat_q + 1'b1);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      addr_q <= 32'h0;
    else if (wbGo)
      addr_q <= {wbLine_q, sequencer_pkg::LINE_OFFSET0};
    else if (cpuGo)
      addr_q <= cpuReqWrite ? cpuReqAddr
                : {sequencer_pkg::line_of(cpuReqAddr), sequencer_pkg::LINE_OFFSET0};
    else if (beatDone)
      addr_q[3:2] <= 2'(addr_q[3:2] + 1'b1);
  end

  // write data and read return; write-back select taken on first ready
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wdata_q <= 32'h0;
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
      fillWb_q <= 1'b0;
    end
    else
    begin
      wdata_q <= cpuReqReady ? cpuReqData : wdata_q;
      rdata_q <= (beatDone && isRead) ? dataIn : rdata_q;
      rvalid_q <= beatDone && isRead;
      if (beatDone && isRead && beat_q == sequencer_pkg::FIRST_BEAT)
        fillWb_q <= lineWritebackSelect;
    end
  end

  // snoop stage one: line and discard qualifier caught with the strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      probeStage_q <= 1'b0;
      snoopLine_q <= 28'h0;
      discard_q <= 1'b0;
    end
    else
    begin
      probeStage_q <= snoopAccept;
      if (snoopAccept)
      begin
        snoopLine_q <= sequencer_pkg::line_of(addrIn);
        discard_q <= snoopDiscardLine;
      end
    end
  end

  // stage two: modified-hit shown; released only after the last beat
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hitmN_q <= sequencer_pkg::SNOOP_MODIFIED_HIT_IDLE;
      wbPend_q <= 1'b0;
      wbLine_q <= 28'h0;
    end
    else if (wbDone)
    begin
      hitmN_q <= sequencer_pkg::SNOOP_MODIFIED_HIT_IDLE;
      wbPend_q <= 1'b0;
    end
    else if (modHit)
    begin
      hitmN_q <= 1'b0;
      wbPend_q <= 1'b1;
      wbLine_q <= snoopLine_q;
    end
  end

  // count words of the modified line entering the buffer
  always_ff @(posedge mclk)
  begin
    if (reset || wbDone)
      loadCnt_q <= 3'h0;
    else if (fifoIn.valid && fifoIn.ready)
      loadCnt_q <= 3'(loadCnt_q + 1'b1);
  end

  // final line state told to the cache once the write-back ends
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      update_q <= 1'b0;
      invalidate_q <= 1'b0;
    end
    else
    begin
      update_q <= wbDone;
      invalidate_q <= wbDone ? discard_q : invalidate_q;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence snoopHitSeq;
    snoopAccept ##1 (probeModified || cbMatch);
  endsequence
  sequence snoopCleanSeq;
    snoopAccept ##1 !(probeModified || cbMatch);
  endsequence
  // data phase of a write-back; stalls bounded well inside the range
  sequence wbBurstSeq;
    (stData && isWb) ##[3:1000] wbDone;
  endsequence

  read_start_a: assert property ((!cycleStartStrobeN && !writeNotRead) |->
    $past(cpuGo && !cpuReqWrite)) else $error("read start without read request");
  write_start_a: assert property ((cpuGo && cpuReqWrite && !wbGo) |=>
    (!cycleStartStrobeN && writeNotRead && burstLineCycleN))
    else $error("write start shape wrong");
  fill_last_a: assert property ((stData && isRead && !burstReadyN) |->
    (finalTransferFlagN == (beat_q != sequencer_pkg::LAST_BEAT)))
    else $error("final flag misplaced in fill");
  hit_timing_a: assert property (snoopHitSeq |=> !snoopModifiedHitN)
    else $error("modified hit not shown two clocks after strobe");
  clean_hit_a: assert property (snoopCleanSeq |=> snoopModifiedHitN)
    else $error("modified hit shown for clean line");
  ack_lag_a: assert property ($rose(busYieldAck) |-> $past(busYieldReq))
    else $error("ack raised without request");
  ack_prompt_a: assert property ((busYieldReq && stIdle && !wbPend_q && !ack_q)
    |=> busYieldAck) else $error("ack late with bus idle");
  ack_after_access_a: assert property ($rose(busYieldAck) |-> $past(stIdle))
    else $error("ack raised during access");
  wb_release_a: assert property (($fell(cycleStartStrobeN) && isWb) |->
    (!$past(busYieldReq) && !burstLineCycleN && writeNotRead
    && addrOut[3:0] == sequencer_pkg::LINE_OFFSET0)) else $error("bad write-back start");
  wb_first_a: assert property ((stIdle && wbPend_q && lineLoaded && !busYieldReq)
    |=> (stAddr && isWb)) else $error("write-back not given priority");
  wb_burst_a: assert property ((stAddr && isWb) |=> wbBurstSeq)
    else $error("write-back burst lost");
  snoop_ignore_a: assert property ((!snoopModifiedHitN && !snoopAddrStrobeN)
    |=> !probeStage_q) else $error("snoop taken while write-back owed");
  hit_release_a: assert property (wbDone |=> (snoopModifiedHitN
    && beat_q == sequencer_pkg::FIRST_BEAT)) else $error("modified hit not released");
  line_state_a: assert property (wbDone |=> (lineStateUpdate
    && lineInvalidate == $past(discard_q))) else $error("line state update wrong");
endmodule : snoop_writeback_bus_sequencer

// file: hw/word_fifo.sv
/*
  synchronous word FIFO with honest full and empty;
  assumes one clock and a synchronous active-high reset
*/
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  word_stream_if.sink inPort,
  word_stream_if.source outPort
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  wire push = inPort.valid && inPort.ready;
  wire pop = outPort.valid && outPort.ready;

  // flags straight from the count so back-pressure is exact
  assign inPort.ready = (count_q != FULL_COUNT);
  assign outPort.valid = (count_q != '0);
  assign outPort.data = mem[rdPtr_q];

  // storage has no reset; only pointers and count need a defined start
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wrPtr_q] <= inPort.data;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= push ? PW'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_q <= pop ? PW'(rdPtr_q + 1'b1) : rdPtr_q;
      count_q <= (PW+1)'(count_q + push - pop);
    end
  end
endmodule : word_fifo

// file: hw/word_stream_if.sv
/*
  valid/ready word stream between the sequencer and its buffer;
  assumes both ends share one clock
*/
`timescale 1ns/100ps
interface word_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : word_stream_if

// file: verification/snoop_writeback_bus_sequencer_bench.sv
/*
  self-checking bench of the write-back bus sequencer; the bench plays the
  cache and the yield and snoop side, the system model answers bus cycles
*/
`timescale 1ns/100ps
module snoop_writeback_bus_sequencer_bench;
  logic mclk = 1'h0, reset = 1'h1, slow = 1'h0, disc = 1'h0;
  logic cpuReqValid = 1'h0, cpuReqWrite = 1'h0, probeModified = 1'h0;
  logic lineWordValid = 1'h0, busYieldReq = 1'h0, snoopAddrStrobeN = 1'h1;
  logic snoopDiscardLine = 1'h0, copyBackValid = 1'h0;
  logic [27:0] copyBackLine = 28'h0;
  logic [31:0] cpuReqAddr = 32'h0, cpuReqData = 32'h0, addrIn = 32'h0, lineWord = 32'h0;
  logic cpuReqReady, cpuReadValid, fillWriteBack, snoopProbe, lineWordReady;
  logic lineStateUpdate, lineInvalidate, cycleStartStrobeN, writeNotRead;
  logic burstLineCycleN, finalTransferFlagN, burstReadyN, lineWritebackSelect;
  logic addrOe, dataOe, busYieldAck, snoopModifiedHitN;
  logic [31:0] cpuReadData, addrOut, dataOut, dataIn;
  logic [27:0] snoopProbeLine, snoopLine;
  logic [31:0] words [4];
  int errCount = 0, checked = 0, seed = 32'h00c8, t, k, b, i;

  snoop_writeback_bus_sequencer dut_u (.mclk, .reset, .cpuReqValid, .cpuReqWrite,
    .cpuReqAddr, .cpuReqData, .cpuReqReady, .cpuReadData, .cpuReadValid, .fillWriteBack,
    .snoopProbe, .snoopProbeLine, .probeModified, .copyBackValid,
    .copyBackLine, .lineWordValid, .lineWord, .lineWordReady, .lineStateUpdate,
    .lineInvalidate, .cycleStartStrobeN, .writeNotRead, .burstLineCycleN,
    .finalTransferFlagN, .burstReadyN, .lineWritebackSelect, .addrOut, .addrOe, .addrIn,
    .dataOut, .dataOe, .dataIn, .busYieldReq, .busYieldAck, .snoopAddrStrobeN,
    .snoopDiscardLine, .snoopModifiedHitN);
  system_logic_model far_u (.mclk, .reset, .slow, .cycleStartStrobeN, .writeNotRead,
    .finalTransferFlagN, .addrOut, .burstReadyN, .lineWritebackSelect, .dataIn);

  always #20 mclk = ~mclk;

  // settled middle of the next cycle, where the checks look
  task automatic nc;
    @(negedge mclk);
    #1;
  endtask : nc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errCount++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // read word the system model returns for a beat of a line
  function automatic logic [31:0] expWord(input logic [27:0] ln, input int beat);
    expWord = {ln, beat[1:0], 2'h0} ^ 32'h3c3c_a5a5;
  endfunction : expWord

  // one processor access, followed beat by beat
  task automatic access(input logic [31:0] a, input logic wr, input logic [31:0] d);
    int beat, rv, tt;
    logic sel;
    beat = 0;
    rv = 0;
    tt = 0;
    sel = 1'h0;
    @(negedge mclk);
    {cpuReqValid, cpuReqWrite, cpuReqAddr, cpuReqData} = {1'h1, wr, a, d};
    #1;
    while (cpuReqReady !== 1'h1 && tt++ < 50) nc();
    @(negedge mclk);
    cpuReqValid = 1'h0;
    #1;
    chk(cycleStartStrobeN, 32'h0);
    chk(writeNotRead, wr);
    chk(burstLineCycleN, wr);
    chk(addrOe, 32'h1);
    chk(addrOut, wr ? a : {a[31:4], 4'h0});
    while ((beat < (wr ? 1 : 4) || (!wr && rv < 4)) && tt++ < 100)
    begin
      nc();
      if (cpuReadValid === 1'h1)
        chk(cpuReadData, expWord(a[31:4], rv++));
      if (burstReadyN === 1'h0)
      begin
        sel = (beat == 0) ? lineWritebackSelect : sel;
        if (wr)
          chk(dataOut, d);
        chk(dataOe, wr);
        chk(finalTransferFlagN, beat != (wr ? 0 : 3));
        beat++;
      end
    end
    chk(beat, wr ? 32'h1 : 32'h4);
    if (!wr)
      chk(fillWriteBack, sel);
  endtask : access

  // acknowledge is registered, so it cannot answer in the request's own cycle
  task automatic yieldUp(output int n);
    @(negedge mclk);
    busYieldReq = 1'h1;
    #1;
    chk(busYieldAck, 32'h0);
    n = 0;
    while (busYieldAck !== 1'h1 && n++ < 20) nc();
    chk(busYieldAck, 32'h1);
  endtask : yieldUp

  // strobe, probe answer the next cycle, result two cycles on
  task automatic snoop(input logic hit, input logic dsc);
    @(negedge mclk);
    snoopAddrStrobeN = 1'h0;
    snoopDiscardLine = dsc;
    addrIn = $random(seed);
    #1;
    snoopLine = addrIn[31:4];
    chk(snoopProbe, 32'h1);
    chk(snoopProbeLine, snoopLine);
    @(negedge mclk);
    snoopAddrStrobeN = 1'h1;
    // a hit with discard set comes from the copy-back buffer, not the cache
    probeModified = hit && !dsc;
    copyBackValid = 1'h1;
    copyBackLine = (hit && dsc) ? snoopLine : ~snoopLine;
    #1;
    chk(snoopModifiedHitN, 32'h1);
    @(negedge mclk);
    probeModified = 1'h0;
    copyBackValid = 1'h0;
    addrIn = ~addrIn;
    #1;
    chk(snoopModifiedHitN, !hit);
  endtask : snoop

  task automatic summarize;
    if (errCount == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // a write-back may not open while the yield request is still up
  always @(negedge mclk)
  begin
    #2;
    if (!reset && cycleStartStrobeN === 1'h0 && !burstLineCycleN && writeNotRead)
      chk(busYieldReq, 32'h0);
  end

  // generous span; the whole sequence needs well under a tenth of it
  initial
  begin
    #(40 * 20000);
    errCount++;
    summarize();
  end

  initial
  begin
    repeat (20) @(negedge mclk);
    reset = 1'h0;
    #1;
    chk(snoopModifiedHitN, 32'h1);
    chk({cycleStartStrobeN, busYieldAck, addrOe, dataOe}, 32'h8);
    // top line as a corner, then random fills and writes, prompt and stalled
    access(32'hffff_fffc, 1'h0, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      slow = i[0];
      k = $random(seed);
      access($random(seed), k[0], $random(seed));
    end
    // yield request raised while a stalled fill runs
    slow = 1'h1;
    fork
      access(32'h0000_1230, 1'h0, 32'h0);
      begin
        repeat (3) @(negedge mclk);
        busYieldReq = 1'h1;
        t = 0;
        #1;
        while (!(burstReadyN === 1'h0 && finalTransferFlagN === 1'h0) && t++ < 60) nc();
        chk(finalTransferFlagN, 32'h0);
        chk(busYieldAck, 32'h0);
        nc();
        chk(busYieldAck, 32'h0);
      end
    join
    t = 0;
    while (busYieldAck !== 1'h1 && t++ < 20) nc();
    chk(busYieldAck, 32'h1);
    @(negedge mclk);
    busYieldReq = 1'h0;
    repeat (3) @(negedge mclk);
    slow = 1'h0;
    yieldUp(t);
    chk(t, 32'h1);
    snoop(1'h0, 1'h0);
    snoop(1'h0, 1'h1);
    // modified hit with a processor write held back behind the write-back
    for (k = 0; k < 2; k++)
    begin
      disc = k[0];
      slow = k[0];
      for (i = 0; i < 4; i++)
        words[i] = $random(seed);
      if (busYieldAck !== 1'h1)
        yieldUp(t);
      {cpuReqValid, cpuReqWrite, cpuReqAddr, cpuReqData} = {2'h3, 32'h0000_4440, words[0]};
      snoop(1'h1, disc);
      @(negedge mclk);
      snoopAddrStrobeN = 1'h0;
      busYieldReq = 1'h0;
      #1;
      chk(snoopProbe, 32'h0);
      chk(cycleStartStrobeN, 32'h1);
      b = 0;
      t = 0;
      while (cycleStartStrobeN !== 1'h0 && t++ < 40)
      begin
        @(negedge mclk);
        snoopAddrStrobeN = 1'h1;
        lineWordValid = (b < 4);
        lineWord = words[b[1:0]];
        #1;
        b = b + (lineWordValid && lineWordReady === 1'h1);
      end
      chk({writeNotRead, burstLineCycleN}, 32'h2);
      chk(addrOut, {snoopLine, 4'h0});
      @(negedge mclk);
      busYieldReq = 1'h1;
      lineWordValid = 1'h0;
      b = 0;
      t = 0;
      #1;
      while (b < 4 && t++ < 60)
      begin
        if (burstReadyN === 1'h0)
        begin
          chk(dataOut, words[b[1:0]]);
          chk(finalTransferFlagN, b != 3);
          chk(snoopModifiedHitN, 32'h0);
          b++;
        end
        nc();
      end
      chk(snoopModifiedHitN, 32'h1);
      chk({lineStateUpdate, lineInvalidate}, {1'h1, disc});
      t = 0;
      while (busYieldAck !== 1'h1 && t++ < 20) nc();
      snoop(1'h0, disc);
      @(negedge mclk);
      busYieldReq = 1'h0;
      t = 0;
      #1;
      while (cpuReqReady !== 1'h1 && t++ < 20) nc();
      @(negedge mclk);
      cpuReqValid = 1'h0;
      #1;
      chk({cycleStartStrobeN, writeNotRead}, 32'h1);
      repeat (6) @(negedge mclk);
    end
    // reset while a write-back is owed must drop it and release the hit
    yieldUp(t);
    snoop(1'h1, 1'h0);
    @(negedge mclk);
    reset = 1'h1;
    repeat (2) @(negedge mclk);
    reset = 1'h0;
    busYieldReq = 1'h0;
    #1;
    chk({snoopModifiedHitN, busYieldAck, lineWordReady}, 32'h4);
    repeat (4) nc();
    chk({cycleStartStrobeN, addrOe}, 32'h2);
    summarize();
  end
endmodule : snoop_writeback_bus_sequencer_bench

// file: verification/system_logic_model.sv
/*
  behavioural core system logic: answers each bus cycle with burst ready,
  write-back select and read data; assumes one clock shared with the
  sequencer and a data phase that opens the cycle after the start strobe
*/
`timescale 1ns/100ps
module system_logic_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  input wire logic cycleStartStrobeN,
  input wire logic writeNotRead,
  input wire logic finalTransferFlagN,
  input wire logic [31:0] addrOut,
  output logic burstReadyN,
  output logic lineWritebackSelect,
  output logic [31:0] dataIn
);
  logic inPhase_q = 1'h0;
  int seed = 32'h00c8;
  int r;
  initial
  begin
    burstReadyN = 1'h1;
    lineWritebackSelect = 1'h0;
    dataIn = 32'h0;
  end
  // phase closes on the beat where flag and ready are both low
  always @(posedge mclk)
  begin
    if (reset)
      inPhase_q <= 1'h0;
    else if (!cycleStartStrobeN)
      inPhase_q <= 1'h1;
    else if (!burstReadyN && !finalTransferFlagN)
      inPhase_q <= 1'h0;
  end
  // slow mode stalls at random; a released data bus never keeps its last value
  always @(negedge mclk)
  begin
    r = $random(seed);
    burstReadyN <= !(inPhase_q && (!slow || r[0]));
    lineWritebackSelect <= r[1];
    dataIn <= (inPhase_q && !writeNotRead) ? (addrOut ^ 32'h3c3c_a5a5) : ~dataIn;
  end
endmodule : system_logic_model
